// ==== dv/are_regs_properties.sv ====
// Port checker for the analyzer register bank, bound into are_regs.
// Assumes pclk as the only clock and presetn as async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module are_regs_chk #(
    parameter longint STABLE_CYCLES = 20
) (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [7:0]            paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire are_pkg::are_meas_type meas,
    input wire logic [15:0]           rtc_read_word,
    input wire logic [7:0]            rtc_set_value,
    input wire logic                  rtc_set_strobe,
    input wire logic signed [15:0]    oxygen_fix2,
    input wire logic signed [15:0]    alarm1_soff,
    input wire are_pkg::are_lamp_type lamps,
    input wire logic [15:0]           status_word
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic unm;
    logic clk_wr;
    // Decode helpers shared by the bus properties.
    assign acc = psel && penable;
    assign unm = !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10});
    assign clk_wr = acc && pwrite && (paddr == are_pkg::ADDR_CLOCK);
    property p_ready;
        acc |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("access phase without pready");
    property p_refuse;
        acc && unm |-> pslverr && prdata == 32'h0000_0000;
    endproperty
    a_refuse: assert property (p_refuse) else $error("unmapped access not refused");
    property p_upper;
        acc |-> prdata[31:16] == 16'h0000;
    endproperty
    a_upper: assert property (p_upper) else $error("upper read half not zero");
    property p_set;
        clk_wr |=> rtc_set_strobe && rtc_set_value == $past(pwdata[7:0]);
    endproperty
    a_set: assert property (p_set) else $error("clock set byte wrong");
    property p_set_src;
        rtc_set_strobe |-> $past(clk_wr);
    endproperty
    a_set_src: assert property (p_set_src) else $error("stray clock strobe");
    property p_spare;
        status_word[15] == 1'b0 && status_word[13:11] == 3'b000;
    endproperty
    a_spare: assert property (p_spare) else $error("spare status bit set");
    property p_prio;
        lamps.red_on |-> !lamps.red_flash;
    endproperty
    a_prio: assert property (p_prio) else $error("flash beside steady red");
    property p_yel;
        $past(status_word[3:2]) == status_word[3:2] |->
            {lamps.yellow2, lamps.yellow1} == status_word[3:2];
    endproperty
    a_yel: assert property (p_yel) else $error("yellow lamps off status");
    property p_red;
        (status_word[10:6] != 5'h00) [*2] |-> lamps.red_on;
    endproperty
    a_red: assert property (p_red) else $error("steady red missing");
    property p_fix;
        ($stable(meas.oxygen_raw) && meas.oxygen_raw <= are_pkg::FIX_MAX) [*5] |->
            oxygen_fix2 == 16'(meas.oxygen_raw - are_pkg::FIX_ZERO);
    endproperty
    a_fix: assert property (p_fix) else $error("two-decimal offset wrong");
    property p_soff;
        $stable(meas.alarm1_lvl) [*5] |->
            alarm1_soff == 16'(meas.alarm1_lvl - are_pkg::SOFF_ZERO);
    endproperty
    a_soff: assert property (p_soff) else $error("signed offset wrong");
endmodule
bind are_regs are_regs_chk #(.STABLE_CYCLES(STABLE_CYCLES)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas(meas), .rtc_read_word(rtc_read_word), .rtc_set_value(rtc_set_value),
    .rtc_set_strobe(rtc_set_strobe), .oxygen_fix2(oxygen_fix2), .alarm1_soff(alarm1_soff),
    .lamps(lamps), .status_word(status_word)
);
`default_nettype wire

// ==== dv/are_regs_tb_top.sv ====
// Self-checking bench for the analyzer register bank over APB.
// Assumes the package and design are compiled first; the checker binds itself.
`timescale 1ns/1ps
`default_nettype none
module are_regs_tb_top;
    logic                  pclk;
    logic                  presetn;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [7:0]            paddr;
    logic [31:0]           pwdata;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic [15:0]           rtc_read_word;
    logic [7:0]            rtc_set_value;
    logic                  rtc_set_strobe;
    logic [15:0]           oxygen_fix2;
    logic [15:0]           alarm1_soff;
    logic [15:0]           status_word;
    are_pkg::are_meas_type meas;
    are_pkg::are_meas_type base;
    are_pkg::are_lamp_type lamps;
    logic [31:0]           r;
    logic                  e;
    int                    n_mismatch = 0;
    int                    tests_run = 0;
    logic [15:0]           uv [12] = '{16'h0000, 16'h0001, 16'h0002, 16'h0004, 16'h0008,
        16'h0010, 16'h0020, 16'h0800, 16'h1000, 16'h1800, 16'h2000, 16'hFFFF};
    logic [15:0]           av [6] = '{16'h0000, 16'h0005, 16'h000A, 16'h0009, 16'h0006, 16'h000F};
    logic [1:0]            ae [6] = '{2'b00, 2'b01, 2'b10, 2'b11, 2'b00, 2'b00};
    logic [15:0]           fv [4][4] = '{'{16'h0000, 16'h0000, 16'hB1E0, 16'h8001},
        '{16'h9C40, 16'hFFFF, 16'h4E20, 16'h8000}, '{16'h55F0, 16'h7FFF, 16'h07D0, 16'h0000},
        '{16'hFFFF, 16'h8000, 16'h4E20, 16'h0001}};

    are_regs #(.STABLE_CYCLES(20), .FLASH_DIV(4)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .meas(meas), .rtc_read_word(rtc_read_word), .rtc_set_value(rtc_set_value),
        .rtc_set_strobe(rtc_set_strobe), .oxygen_fix2(oxygen_fix2), .alarm1_soff(alarm1_soff),
        .lamps(lamps), .status_word(status_word)
    );
    are_rtc_model u_rtc (.pclk(pclk), .presetn(presetn), .rtc_set_value(rtc_set_value),
        .rtc_set_strobe(rtc_set_strobe), .rtc_read_word(rtc_read_word));

    ////////////////////////////////////////////////////////////////////////////////
    // Free-running 100 MHz clock.
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; the request holds until pready is seen high at an edge.
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask

    task automatic rd(input logic [7:0] a);
        apb(a, 1'b0, 32'h0000_0000);
    endtask

    // Applies one measurement fault, checks the status word and lamps, then heals.
    task automatic fault(input int f, input logic [15:0] v, input logic [15:0] x);
        are_pkg::are_meas_type m;
        logic                  fl;
        m = base;
        fl = 1'b0;
        case (f)
            0: m.comp_ua = v;
            1: m.cell_t = v;
            2: m.press_mbar = v;
            3: m.vcomp = v[12:0];
            4: m.board_t = v;
            5: m.oxygen_out_range = v[0];
            default: begin
                m.comp_ua = 16'h0E0F;
                m.press_mbar = v;
            end
        endcase
        meas <= m;
        repeat (6) @(posedge pclk);
        rd(are_pkg::ADDR_STATUS);
        chk(r & 32'h0000_07F2, x);
        repeat (10) begin
            @(posedge pclk);
            fl = fl | lamps.red_flash;
        end
        chk({lamps.red_on, fl}, {|x[10:6], x[4] && !(|x[10:6])});
        meas <= base;
        repeat (30) @(posedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog: the tests need about a thousand cycles, so 50000 means a hang.
    initial begin
        #500_000;
        n_mismatch++;
        summarize();
    end

    // Main sequence of register and measurement scenarios.
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        base = '0;
        base.comp_ua = 16'h2EE0;
        base.cell_t = 16'h02BC;
        base.cell_sp = 16'h02BC;
        base.board_t = 16'h012C;
        base.press_mbar = 16'h03E8;
        base.vcomp = 13'h0FA0;
        base.oxygen_raw = 16'h55F0;
        base.alarm1_lvl = 16'h61A8;
        base.alarm2_lvl = 16'h5208;
        meas = base;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (5) @(posedge pclk);
        rd(are_pkg::ADDR_STATUS);
        chk(r, 32'h0000_4040);
        rd(are_pkg::ADDR_UNITS);
        chk(r, are_pkg::UNITS_RESET);
        rd(are_pkg::ADDR_ALARM);
        chk(r, are_pkg::ALARM_RESET);
        repeat (30) @(posedge pclk);
        rd(are_pkg::ADDR_STATUS);
        chk(r, 32'h0000_4000);
        foreach (uv[i]) begin
            wr(are_pkg::ADDR_UNITS, {16'hFFFF, uv[i]});
            rd(are_pkg::ADDR_UNITS);
            chk(r, uv[i] & are_pkg::UNITS_MASK);
        end
        foreach (av[i]) begin
            wr(are_pkg::ADDR_ALARM, av[i]);
            rd(are_pkg::ADDR_ALARM);
            chk(r, av[i] & are_pkg::ALARM_MASK);
            rd(are_pkg::ADDR_STATUS);
            chk(r[3:2], ae[i]);
            chk({lamps.yellow2, lamps.yellow1}, ae[i]);
        end
        wr(are_pkg::ADDR_FLAGS, 32'h0000_0001);
        rd(are_pkg::ADDR_STATUS);
        chk(r[0], 1'b1);
        wr(are_pkg::ADDR_FLAGS, 32'h0000_0000);
        rd(are_pkg::ADDR_STATUS);
        chk(r[0], 1'b0);
        wr(are_pkg::ADDR_CLOCK, 32'hFFFF_FF34);
        wr(are_pkg::ADDR_CLOCK, 32'h0000_AB12);
        repeat (5) @(posedge pclk);
        chk(rtc_set_value, 8'h12);
        rd(are_pkg::ADDR_CLOCK);
        chk(r, 32'h0000_3412);
        wr(are_pkg::ADDR_STATUS, 32'h0000_FFFF);
        rd(8'h14);
        chk({e, r[30:0]}, 32'h8000_0000);
        rd(are_pkg::ADDR_STATUS);
        chk(r, 32'h0000_4000);
        fault(0, 16'h0E0F, 16'h0010);
        fault(0, 16'h0E10, 16'h0000);
        fault(0, 16'h5209, 16'h0010);
        fault(1, 16'h02C1, 16'h0000);
        fault(1, 16'h02C2, 16'h0040);
        fault(1, 16'hFE0B, 16'h00C0);
        fault(1, 16'h0321, 16'h00C0);
        fault(2, 16'h0351, 16'h0100);
        fault(2, 16'h044C, 16'h0000);
        fault(2, 16'h044D, 16'h0100);
        fault(3, 16'h0001, 16'h0200);
        fault(3, 16'h0002, 16'h0000);
        fault(3, 16'h1FFF, 16'h0200);
        fault(4, 16'h02BD, 16'h0400);
        fault(5, 16'h0001, 16'h0002);
        fault(6, 16'h0351, 16'h0110);
        foreach (fv[i]) begin
            base.oxygen_raw = fv[i][0];
            base.alarm1_lvl = fv[i][1];
            meas <= base;
            repeat (6) @(posedge pclk);
            chk(oxygen_fix2, fv[i][2]);
            chk(alarm1_soff, fv[i][3]);
        end
        summarize();
    end
endmodule
`default_nettype wire

// ==== dv/are_rtc_model.sv ====
// Real-time clock model standing behind the clock set and read pins.
// Assumes set strobes last one pclk cycle.
`timescale 1ns/1ps
`default_nettype none
module are_rtc_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  rtc_set_value,
    input  wire logic        rtc_set_strobe,
    output logic [15:0]      rtc_read_word
);
    // Each set shifts one byte in, so a read shows two clock bytes at once.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rtc_read_word <= 16'h0000;
        end else if (rtc_set_strobe) begin
            rtc_read_word <= {rtc_read_word[7:0], rtc_set_value};
        end
    end
endmodule
`default_nettype wire

// ==== logic/are_limit_check.sv ====
// Checks one signed value against an inclusive window and reports out-of-window.
// Assumes inputs on the pclk domain.

`timescale 1ns/1ps
`default_nettype none

module are_limit_check #(
    parameter int W = 16
) (
    input  wire logic signed [W-1:0] value,
    input  wire logic signed [W-1:0] lo,
    input  wire logic signed [W-1:0] hi,
    output logic                     outside
);

    // Strict comparisons; the bounds themselves are in range.
    assign outside = (value < lo) || (value > hi);

endmodule

`default_nettype wire

// ==== logic/are_pkg.sv ====
// Package for the analyzer register encoding block: offsets, fields, codes, timing.
// Assumes a 32-bit APB slave at 100 MHz with one register per aligned word.

package are_pkg;

    // Register byte offsets.
    localparam logic [7:0] ADDR_UNITS   = 8'h00;
    localparam logic [7:0] ADDR_STATUS  = 8'h04;
    localparam logic [7:0] ADDR_CLOCK   = 8'h08;
    localparam logic [7:0] ADDR_ALARM   = 8'h0C;
    localparam logic [7:0] ADDR_FLAGS   = 8'h10;

    // Writable bit masks; spare bits read as zero.
    localparam logic [15:0] UNITS_MASK  = 16'h383F;
    localparam logic [15:0] ALARM_MASK  = 16'h000F;
    localparam logic [15:0] UNITS_RESET = 16'h0000;
    localparam logic [15:0] ALARM_RESET = 16'h0000;
    localparam logic [7:0]  CLOCK_RESET = 8'h00;

    // Units word field positions.
    localparam int TEMP_LSB  = 0;
    localparam int PRESS_LSB = 2;
    localparam int CAL_BIT   = 4;
    localparam int DATE_BIT  = 5;
    localparam int EXT_LSB   = 11;

    // Status word bit positions.
    localparam int ST_FILT  = 0;
    localparam int ST_RANGE = 1;
    localparam int ST_AL1   = 2;
    localparam int ST_AL2   = 3;
    localparam int ST_COMP  = 4;
    localparam int ST_CELLU = 6;
    localparam int ST_CELLS = 7;
    localparam int ST_PRESS = 8;
    localparam int ST_O2    = 9;
    localparam int ST_BOARD = 10;
    localparam int ST_XMTR  = 14;

    // Flags register bits (soft filter setting).
    localparam int FL_FILTER = 0;

    // Offset-coded format constants.
    localparam logic [15:0] FIX_ZERO  = 16'h4E20;  // 20000
    localparam logic [15:0] FIX_MAX   = 16'h9C40;  // 40000
    localparam logic [15:0] SOFF_ZERO = 16'h7FFF;  // 32767

    // Limits on signed and unsigned physical inputs (tenths of a unit or plain units).
    localparam logic signed [15:0] COMP_LO_UA   = 16'sd3600;
    localparam logic signed [15:0] COMP_HI_UA   = 16'sd21000;
    localparam logic signed [15:0] CELL_LO      = -16'sd500;  // tenths degC
    localparam logic signed [15:0] CELL_HI      = 16'sd800;
    localparam logic signed [15:0] STABLE_BAND  = 16'sd5;
    localparam logic [15:0]        PRESS_LO     = 16'd850;
    localparam logic [15:0]        PRESS_HI     = 16'd1100;
    localparam logic [12:0]        VCOMP_LO     = 13'd1;
    localparam logic [12:0]        VCOMP_HI     = 13'd8191;

    // Stability window and cycles at 100 MHz.
    localparam longint STABLE_MIN    = 5;
    localparam longint CLK_HZ        = 100_000_000;
    localparam longint STABLE_CYCLES = STABLE_MIN * 60 * CLK_HZ;

    // Alarm mode codes.
    typedef enum logic [1:0] {ARE_AL_OFF, ARE_AL_LOW, ARE_AL_HIGH, ARE_AL_RSVD} are_alarm_type;

    // Physical measurement bundle.
    typedef struct packed {
        logic signed [15:0] comp_ua;
        logic signed [15:0] cell_t;
        logic signed [15:0] cell_sp;
        logic signed [15:0] board_t;
        logic [15:0]        press_mbar;
        logic [12:0]        vcomp;
        logic [15:0]        oxygen_raw;
        logic [15:0]        alarm1_lvl;
        logic [15:0]        alarm2_lvl;
        logic               oxygen_out_range;
    } are_meas_type;

    // Indicator lamp bundle.
    typedef struct packed {
        logic yellow1;
        logic yellow2;
        logic red_on;
        logic red_flash;
    } are_lamp_type;

endpackage

// ==== logic/are_regs.sv ====
// APB register bank encoding the units, status, clock and alarm words.
// Assumes measurements arrive on pins, async to pclk, and pass a synchroniser here.
//
// What this block does
// - Units bits 1:0 temperature unit, bits 3:2 external pressure unit.
// - Units bit 4 selects offset or two-gas field calibration.
// - Units bit 5 selects non-US or US date order.
// - Units bits 13:11 external sensor quantity; other high bits spare.
// - One-decimal format: raw 0..40000, value (raw-20000)/10.
// - Two-decimal format: raw 0..40000, value (raw-20000)/100.
// - Status bit 0 shows filtered or plain oxygen per setting.
// - Status bit 1 set while oxygen beyond calibrated range; no lamp.
// - Status bit 4 compensation current below 3.6 or above 21 mA; red flash.
// - Status bit 6 set until cell within 0.5 degC for 5 minutes.
// - Status bit 7 cell temperature below -50 or above 80 degC.
// - Status bit 8 pressure below 850 or above 1100 mbar.
// - Status bit 9 compensation voltage at most 1 or at least 8191.
// - Status bit 10 board temperature above cell setpoint.
// - Status bit 14 marks transmitter variant; bits 11-13,15 zero.
// - Clock reads pack two bytes; clock writes use the low byte only.
// - Signed offset format: value equals raw minus 32767.
// - Alarm word bits 1:0 set alarm one off, low or high.
// - Alarm word bits 3:2 set alarm two off, low or high.

`timescale 1ns/1ps
`default_nettype none

module are_regs #(
    parameter longint STABLE_CYCLES = are_pkg::STABLE_CYCLES,
    parameter bit     TRANSMITTER   = 1'b1,
    parameter int     FLASH_DIV     = 50_000_000
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire are_pkg::are_meas_type meas,
    input  wire logic [15:0]          rtc_read_word,
    output logic [7:0]                rtc_set_value,
    output logic                      rtc_set_strobe,
    output logic signed [15:0]        oxygen_fix2,
    output logic signed [15:0]        alarm1_soff,
    output are_pkg::are_lamp_type     lamps,
    output logic [15:0]               status_word
);

    ////////////////////////////////////////////////////////////////////////
    // Input synchroniser: two stages before any logic reads the pins.

    are_pkg::are_meas_type meas_s1_q;
    are_pkg::are_meas_type meas_q;
    logic [15:0]           rtc_s1_q;
    logic [15:0]           rtc_q;

    // First stage feeds only the second.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meas_s1_q <= '0;
            meas_q    <= '0;
            rtc_s1_q  <= 16'h0000;
            rtc_q     <= 16'h0000;
        end else begin
            meas_s1_q <= meas;
            meas_q    <= meas_s1_q;
            rtc_s1_q  <= rtc_read_word;
            rtc_q     <= rtc_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB decode.

    logic apb_wr;
    logic apb_rd;
    logic addr_ok;

    assign apb_wr  = psel && penable && pwrite;
    assign apb_rd  = psel && penable && !pwrite;
    assign addr_ok = (paddr == are_pkg::ADDR_UNITS) || (paddr == are_pkg::ADDR_STATUS)
                  || (paddr == are_pkg::ADDR_CLOCK) || (paddr == are_pkg::ADDR_ALARM)
                  || (paddr == are_pkg::ADDR_FLAGS);

    // Zero wait states once out of reset; a flop keeps every port registered.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Writable registers.

    logic [15:0] units_config_q;
    logic [15:0] alarm_config_q;
    logic        filter_on_q;

    // Spare bits are masked so they always read zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            units_config_q <= are_pkg::UNITS_RESET;
        end else if (apb_wr && paddr == are_pkg::ADDR_UNITS) begin
            units_config_q <= pwdata[15:0] & are_pkg::UNITS_MASK;
        end
    end

    // Reserved alarm code 11 is stored but treated as inactive.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_config_q <= are_pkg::ALARM_RESET;
        end else if (apb_wr && paddr == are_pkg::ADDR_ALARM) begin
            alarm_config_q <= pwdata[15:0] & are_pkg::ALARM_MASK;
        end
    end

    // Fast-response filter setting that status bit 0 reports.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filter_on_q <= 1'b0;
        end else if (apb_wr && paddr == are_pkg::ADDR_FLAGS) begin
            filter_on_q <= pwdata[are_pkg::FL_FILTER];
        end
    end

    // Clock writes take only the low byte; the upper byte is ignored.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rtc_set_value  <= are_pkg::CLOCK_RESET;
            rtc_set_strobe <= 1'b0;
        end else begin
            rtc_set_strobe <= apb_wr && paddr == are_pkg::ADDR_CLOCK;
            if (apb_wr && paddr == are_pkg::ADDR_CLOCK) begin
                rtc_set_value <= pwdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Error detectors.

    logic comp_err;
    logic cell_err;
    logic signed [15:0] cell_delta;
    logic cell_in_band;
    logic press_err;
    logic o2_err;
    logic board_err;

    are_limit_check #(
        .W (16)
    ) u_comp_chk (
        .value   (meas_q.comp_ua),
        .lo      (are_pkg::COMP_LO_UA),
        .hi      (are_pkg::COMP_HI_UA),
        .outside (comp_err)
    );

    assign cell_err   = (meas_q.cell_t < are_pkg::CELL_LO)
                     || (meas_q.cell_t > are_pkg::CELL_HI);
    assign cell_delta = meas_q.cell_t - meas_q.cell_sp;
    assign cell_in_band = (cell_delta <= are_pkg::STABLE_BAND)
                       && (cell_delta >= -are_pkg::STABLE_BAND);
    assign press_err  = (meas_q.press_mbar < are_pkg::PRESS_LO)
                     || (meas_q.press_mbar > are_pkg::PRESS_HI);
    assign o2_err     = (meas_q.vcomp <= are_pkg::VCOMP_LO)
                     || (meas_q.vcomp >= are_pkg::VCOMP_HI);
    assign board_err  = meas_q.board_t > meas_q.cell_sp;

    ////////////////////////////////////////////////////////////////////////
    // Stability timer: any excursion restarts the five-minute wait.

    logic [35:0] stable_cnt_q;
    logic        cell_unstable_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stable_cnt_q    <= 36'h0;
            cell_unstable_q <= 1'b1;
        end else if (!cell_in_band) begin
            stable_cnt_q    <= 36'h0;
            cell_unstable_q <= 1'b1;
        end else if (stable_cnt_q >= 36'(STABLE_CYCLES - 1)) begin
            cell_unstable_q <= 1'b0;
        end else begin
            stable_cnt_q <= stable_cnt_q + 36'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Alarm evaluation against the two-decimal oxygen reading.

    logic al1_act;
    logic al2_act;

    // Alarm compare on raw offset-coded values keeps order since the offset is common.
    function automatic logic alarm_eval(input logic [1:0] mode, input logic [15:0] val,
                                        input logic [15:0] lvl);
        logic r;
        r = 1'b0;
        if (mode == 2'(are_pkg::ARE_AL_LOW)) r = val < lvl;
        else if (mode == 2'(are_pkg::ARE_AL_HIGH)) r = val > lvl;
        return r;
    endfunction

    assign al1_act = alarm_eval(alarm_config_q[1:0], meas_q.oxygen_raw, meas_q.alarm1_lvl);
    assign al2_act = alarm_eval(alarm_config_q[3:2], meas_q.oxygen_raw, meas_q.alarm2_lvl);

    ////////////////////////////////////////////////////////////////////////
    // Status word assembly.

    logic [15:0] status_d;

    always_comb begin
        status_d                      = 16'h0000;
        status_d[are_pkg::ST_FILT]    = filter_on_q;
        status_d[are_pkg::ST_RANGE]   = meas_q.oxygen_out_range;
        status_d[are_pkg::ST_AL1]     = al1_act;
        status_d[are_pkg::ST_AL2]     = al2_act;
        status_d[are_pkg::ST_COMP]    = comp_err;
        status_d[are_pkg::ST_CELLU]   = cell_unstable_q;
        status_d[are_pkg::ST_CELLS]   = cell_err;
        status_d[are_pkg::ST_PRESS]   = press_err;
        status_d[are_pkg::ST_O2]      = o2_err;
        status_d[are_pkg::ST_BOARD]   = board_err;
        status_d[are_pkg::ST_XMTR]    = TRANSMITTER;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_word <= 16'h0000;
        end else begin
            status_word <= status_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lamps: red flash blinks at a divided rate.

    logic [31:0] flash_cnt_q;
    logic        flash_phase_q;
    logic        red_steady;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_cnt_q   <= 32'h0;
            flash_phase_q <= 1'b0;
        end else if (flash_cnt_q == 32'(FLASH_DIV - 1)) begin
            flash_cnt_q   <= 32'h0;
            flash_phase_q <= !flash_phase_q;
        end else begin
            flash_cnt_q <= flash_cnt_q + 32'h1;
        end
    end

    assign red_steady = |status_d[are_pkg::ST_BOARD:are_pkg::ST_CELLU];

    // Steady red masks the flash so an operator sees the worse fault.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lamps <= '0;
        end else begin
            lamps.yellow1   <= al1_act;
            lamps.yellow2   <= al2_act;
            lamps.red_on    <= red_steady;
            lamps.red_flash <= comp_err && !red_steady && flash_phase_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Encoded outputs: decoded values of the offset formats.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oxygen_fix2 <= 16'sh0000;
            alarm1_soff <= 16'sh0000;
        end else begin
            // Hundredths of percent; raw above 40000 is clamped.
            if (meas_q.oxygen_raw > are_pkg::FIX_MAX) begin
                oxygen_fix2 <= $signed(are_pkg::FIX_MAX - are_pkg::FIX_ZERO);
            end else begin
                oxygen_fix2 <= $signed(meas_q.oxygen_raw - are_pkg::FIX_ZERO);
            end
            alarm1_soff <= $signed(meas_q.alarm1_lvl - are_pkg::SOFF_ZERO);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data and error response.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel && !penable && !addr_ok;
            prdata  <= 32'h0;
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    are_pkg::ADDR_UNITS:  prdata <= {16'h0000, units_config_q};
                    are_pkg::ADDR_STATUS: prdata <= {16'h0000, status_d};
                    are_pkg::ADDR_CLOCK:  prdata <= {16'h0000, rtc_q};
                    are_pkg::ADDR_ALARM:  prdata <= {16'h0000, alarm_config_q};
                    are_pkg::ADDR_FLAGS:  prdata <= {31'h0, filter_on_q};
                    default:              prdata <= 32'h0;
                endcase
            end
        end
    end

    logic unused_ok;
    assign unused_ok = apb_rd & addr_ok;

endmodule

`default_nettype wire
